//--- include/pbwc_pkg.sv
// constants and types for the push-button wiper control block
// assumes a 100 MHz core clock and a simple nonvolatile store port outside
package pbwc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  // one tick per millisecond from the free-running timebase
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEBOUNCE_MS = 15;
  localparam int REPEAT_START_MS = 250;
  localparam int SLOW_PERIOD_MS = 250;
  localparam int FAST_AFTER_MS = 1000;
  localparam int FAST_PERIOD_MS = 50;
  localparam int IDLE_SAVE_MS = 2000;
  localparam int SHUTDOWN_MS = 2000;
  localparam int MS_W = 12;
  localparam int POS_W = 5;
  localparam int TAPS = 32;
  localparam logic [POS_W-1:0] POS_MAX = 5'h1f;
  localparam logic [POS_W-1:0] POS_MIN = 5'h00;
  localparam logic [POS_W-1:0] POS_RESET = 5'h10;

  typedef enum logic [2:0] {
    PBWC_IDLE, PBWC_HOLD, PBWC_MULTI, PBWC_SAVE, PBWC_SHUT, PBWC_WAKE
  } pbwc_state_e;

  // the three debounced button levels, true while pressed
  typedef struct packed {
    logic up;
    logic down;
    logic store;
  } pbwc_btn_s;
endpackage

//--- hdl/pbwc_wiper_ctrl.sv
// push-button wiper control: debounce, auto-repeat, save, recall, shutdown
// assumes an outside nonvolatile store that answers a write with a done pulse
// and presents its saved value on nv_rd_data from reset release onward
`timescale 1ns/10ps
module pbwc_wiper_ctrl #(
  // cycles per millisecond tick; a bench may shrink it to keep runs short
  parameter int TICK_CYCLES = pbwc_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic step_up_button_n,
  input wire logic step_down_button_n,
  input wire logic store_mode_select_n,
  input wire logic [pbwc_pkg::POS_W-1:0] nv_rd_data,
  input wire logic nv_wr_done,
  output logic nv_wr_start,
  output logic [pbwc_pkg::POS_W-1:0] nv_wr_data,
  output logic [pbwc_pkg::TAPS-1:0] tap_select,
  output logic chain_top_terminal,
  output logic [pbwc_pkg::POS_W-1:0] wiper_pos
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end
    else
    begin
      sync1_reg <= {step_up_button_n, step_down_button_n, store_mode_select_n};
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick from a single free-running counter
  logic [16:0] tick_cnt_reg;
  logic tick_reg;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == 17'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 17'h0001;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debounce: a level is accepted after it stays put for the interval
  logic [2:0] raw_press;
  assign raw_press = ~sync2_reg; // active low pins
  logic [2:0] db_reg;
  logic [4:0] db_cnt_reg [3];
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_db
      always_ff @(posedge core_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          db_reg[g] <= 1'b0;
          db_cnt_reg[g] <= '0;
        end
        else if (raw_press[g] == db_reg[g])
          db_cnt_reg[g] <= '0;
        else if (tick_reg)
        begin
          // glitches shorter than the interval reset the count
          if (db_cnt_reg[g] == 5'(pbwc_pkg::DEBOUNCE_MS - 1))
          begin
            db_reg[g] <= raw_press[g];
            db_cnt_reg[g] <= '0;
          end
          else
            db_cnt_reg[g] <= db_cnt_reg[g] + 5'h01;
        end
      end
    end
  endgenerate
  pbwc_pkg::pbwc_btn_s btn;
  assign btn = '{up: db_reg[2], down: db_reg[1], store: db_reg[0]};

  // raw-level skew between the two step inputs for the shutdown window
  logic [4:0] skew_cnt_reg;
  logic skew_bad_reg;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      skew_cnt_reg <= '0;
      skew_bad_reg <= 1'b0;
    end
    else
    begin
      if (raw_press[2] == raw_press[1])
        skew_cnt_reg <= '0;
      else if (tick_reg && skew_cnt_reg != 5'(pbwc_pkg::DEBOUNCE_MS))
        skew_cnt_reg <= skew_cnt_reg + 5'h01;
      if (!raw_press[2] && !raw_press[1])
        skew_bad_reg <= 1'b0;
      else if (raw_press[2] != raw_press[1] && skew_cnt_reg == 5'(pbwc_pkg::DEBOUNCE_MS))
        skew_bad_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up capture of the store mode and the lock-out it implies
  logic auto_mode_reg;
  logic captured_reg;
  logic [1:0] settle_reg;
  logic lockout_reg;
  logic store_q_reg;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      auto_mode_reg <= 1'b0;
      captured_reg <= 1'b0;
      settle_reg <= 2'h0;
      lockout_reg <= 1'b0;
      store_q_reg <= 1'b0;
    end
    else
    begin
      store_q_reg <= btn.store;
      if (!captured_reg)
      begin
        // strap taken only once the synchroniser holds the real pin level
        settle_reg <= {settle_reg[0], 1'b1};
        captured_reg <= settle_reg[1];
        auto_mode_reg <= raw_press[0];
      end
      else if (!auto_mode_reg)
        lockout_reg <= btn.store;
    end
  end
  logic manual_save;
  assign manual_save = !auto_mode_reg && captured_reg && store_q_reg && !btn.store;
  // in auto mode the store pin is a strap, not a button
  logic store_act;
  assign store_act = btn.store && !auto_mode_reg;

  ////////////////////////////////////////////////////////////////////////
  // main control state machine
  pbwc_pkg::pbwc_state_e state_reg;
  logic [pbwc_pkg::MS_W-1:0] hold_ms_reg;
  logic [pbwc_pkg::MS_W-1:0] rep_ms_reg;
  logic [pbwc_pkg::MS_W-1:0] idle_ms_reg;
  logic [pbwc_pkg::POS_W-1:0] pos_reg;
  logic dirty_reg;
  logic shut_reg;
  logic nv_start_reg;
  logic loaded_reg;
  logic step_up_now;
  logic step_dn_now;
  logic any_btn;
  logic both_steps;
  assign any_btn = btn.up || btn.down || store_act;
  assign both_steps = btn.up && btn.down;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= pbwc_pkg::PBWC_IDLE;
      hold_ms_reg <= '0;
      rep_ms_reg <= '0;
      step_up_now <= 1'b0;
      step_dn_now <= 1'b0;
      shut_reg <= 1'b0;
    end
    else
    begin
      step_up_now <= 1'b0;
      step_dn_now <= 1'b0;
      unique case (state_reg)
        pbwc_pkg::PBWC_IDLE:
        begin
          hold_ms_reg <= '0;
          rep_ms_reg <= '0;
          if (nv_start_reg)
            state_reg <= pbwc_pkg::PBWC_SAVE;
          else if (btn.up && btn.down)
            state_reg <= pbwc_pkg::PBWC_MULTI;
          else if ((btn.up || btn.down) && !lockout_reg && loaded_reg)
          begin
            if (store_act)
              state_reg <= pbwc_pkg::PBWC_MULTI;
            else
            begin
              step_up_now <= btn.up; // first step of a press
              step_dn_now <= btn.down;
              state_reg <= pbwc_pkg::PBWC_HOLD;
            end
          end
        end
        pbwc_pkg::PBWC_HOLD:
        begin
          if (!(btn.up || btn.down))
            state_reg <= pbwc_pkg::PBWC_IDLE;
          else if (both_steps || store_act)
            state_reg <= pbwc_pkg::PBWC_MULTI;
          else if (tick_reg)
          begin
            if (hold_ms_reg != '1)
              hold_ms_reg <= hold_ms_reg + 12'h001;
            rep_ms_reg <= rep_ms_reg + 12'h001;
            // repeat begins past 250 ms, slow until 1 s, fast after
            if (hold_ms_reg < 12'(pbwc_pkg::FAST_AFTER_MS))
            begin
              if (rep_ms_reg == 12'(pbwc_pkg::SLOW_PERIOD_MS - 1))
              begin
                rep_ms_reg <= '0;
                step_up_now <= btn.up && raw_press[2]; // no step once the pin lets go
                step_dn_now <= btn.down && raw_press[1];
              end
            end
            else if (rep_ms_reg >= 12'(pbwc_pkg::FAST_PERIOD_MS - 1))
            begin
              rep_ms_reg <= '0;
              step_up_now <= btn.up && raw_press[2];
              step_dn_now <= btn.down && raw_press[1];
            end
          end
        end
        pbwc_pkg::PBWC_MULTI:
        begin
          // both steps held together from a clean start count toward shutdown
          if (both_steps && !store_act && !skew_bad_reg)
          begin
            if (tick_reg)
              hold_ms_reg <= hold_ms_reg + 12'h001;
            if (hold_ms_reg == 12'(pbwc_pkg::SHUTDOWN_MS))
            begin
              shut_reg <= 1'b1;
              state_reg <= pbwc_pkg::PBWC_WAKE;
            end
          end
          else
            hold_ms_reg <= '0;
          if (!any_btn)
            state_reg <= pbwc_pkg::PBWC_IDLE; // commands discarded
        end
        pbwc_pkg::PBWC_SAVE:
        begin
          // inputs ignored until the write finishes
          if (nv_wr_done)
            state_reg <= pbwc_pkg::PBWC_IDLE;
        end
        pbwc_pkg::PBWC_WAKE:
        begin
          // wait for all buttons to be released before shutdown can exit
          if (!any_btn)
            state_reg <= pbwc_pkg::PBWC_SHUT;
        end
        pbwc_pkg::PBWC_SHUT:
        begin
          // exit only restores, the press makes no step
          if (any_btn)
          begin
            shut_reg <= 1'b0;
            state_reg <= pbwc_pkg::PBWC_MULTI;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // position counter with saturation and power-up recall
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos_reg <= pbwc_pkg::POS_RESET;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      pos_reg <= nv_rd_data;
      loaded_reg <= 1'b1;
    end
    else if (shut_reg)
      pos_reg <= pos_reg;
    else if (step_up_now && pos_reg != pbwc_pkg::POS_MAX)
      pos_reg <= pos_reg + 5'h01;
    else if (step_dn_now && pos_reg != pbwc_pkg::POS_MIN)
      pos_reg <= pos_reg - 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // save requests: idle timer in auto mode, store release in manual mode
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idle_ms_reg <= '0;
      dirty_reg <= 1'b0;
      nv_start_reg <= 1'b0;
      nv_wr_data <= '0;
    end
    else
    begin
      nv_start_reg <= 1'b0;
      if (step_up_now || step_dn_now)
        dirty_reg <= 1'b1;
      if (btn.up || btn.down)
        idle_ms_reg <= '0;
      else if (tick_reg && idle_ms_reg != 12'(pbwc_pkg::IDLE_SAVE_MS))
        idle_ms_reg <= idle_ms_reg + 12'h001;
      if (state_reg == pbwc_pkg::PBWC_IDLE && !nv_start_reg && !shut_reg)
      begin
        // in auto mode only a changed position is written, to spare endurance; a manual store released in PBWC_IDLE writes even an unchanged one
        if (auto_mode_reg && dirty_reg
            && idle_ms_reg == 12'(pbwc_pkg::IDLE_SAVE_MS))
        begin
          nv_start_reg <= 1'b1;
          nv_wr_data <= pos_reg;
          dirty_reg <= 1'b0;
        end
        else if (manual_save)
        begin
          nv_start_reg <= 1'b1;
          nv_wr_data <= pos_reg;
        end
      end
    end
  end
  assign nv_wr_start = nv_start_reg;

  ////////////////////////////////////////////////////////////////////////
  // tap decode, one-hot; shutdown forces the lowest tap and opens the top
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tap_select <= 32'h0000_0001 << pbwc_pkg::POS_RESET;
      chain_top_terminal <= 1'b1;
      wiper_pos <= pbwc_pkg::POS_RESET;
    end
    else
    begin
      wiper_pos <= shut_reg ? pbwc_pkg::POS_MIN : pos_reg;
      tap_select <= 32'h0000_0001 << (shut_reg ? pbwc_pkg::POS_MIN : pos_reg);
      chain_top_terminal <= !shut_reg;
    end
  end

endmodule

//--- verif/pbwc_wiper_ctrl_asserts.sv
// concurrent checks on the ports of the push-button wiper control
// assumes a bind onto pbwc_wiper_ctrl, a 100 MHz clock and a 1 ms timebase
`timescale 1ns/10ps
module pbwc_wiper_ctrl_chk #(
  parameter int TICK_CYCLES = pbwc_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic step_up_button_n,
  input wire logic step_down_button_n,
  input wire logic store_mode_select_n,
  input wire logic [pbwc_pkg::POS_W-1:0] nv_rd_data,
  input wire logic nv_wr_done,
  input wire logic nv_wr_start,
  input wire logic [pbwc_pkg::POS_W-1:0] nv_wr_data,
  input wire logic [pbwc_pkg::TAPS-1:0] tap_select,
  input wire logic chain_top_terminal,
  input wire logic [pbwc_pkg::POS_W-1:0] wiper_pos
);
  // 14 ms: the tick phase may shave up to one tick off the 15 tick filter
  localparam logic [31:0] MIN_LOW = 32'(14 * TICK_CYCLES);
  localparam logic [31:0] IDLE_LONG = 32'(30 * TICK_CYCLES);
  localparam logic [31:0] SHUT_LOW = 32'(1990 * TICK_CYCLES);
  logic [1:0] live_reg;
  logic [31:0] up_low_reg;
  logic [31:0] dn_low_reg;
  logic [31:0] idle_reg;
  logic busy_reg;
  logic [pbwc_pkg::POS_W-1:0] pre_shut_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // settle guard: the first edges after release load the recalled value
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      live_reg <= 2'h0;
    else if (live_reg != 2'h3)
      live_reg <= live_reg + 2'h1;
  // saturating lengths of the current low or idle stretch on the pins
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      up_low_reg <= 32'h0;
      dn_low_reg <= 32'h0;
      idle_reg <= 32'h0;
    end
    else
    begin
      up_low_reg <= step_up_button_n ? 32'h0 : up_low_reg + {31'h0, ~&up_low_reg};
      dn_low_reg <= step_down_button_n ? 32'h0 : dn_low_reg + {31'h0, ~&dn_low_reg};
      idle_reg <= (step_up_button_n && step_down_button_n) ?
        idle_reg + {31'h0, ~&idle_reg} : 32'h0;
    end
  // one write in flight between start and done
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      busy_reg <= 1'b0;
    else if (nv_wr_start)
      busy_reg <= 1'b1;
    else if (nv_wr_done)
      busy_reg <= 1'b0;
  // last position seen while the chain top was still connected
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      pre_shut_reg <= pbwc_pkg::POS_RESET;
    else if (chain_top_terminal)
      pre_shut_reg <= wiper_pos;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_connected;
    live_reg == 2'h3 && chain_top_terminal && $past(chain_top_terminal);
  endsequence
  sequence s_restored;
    (wiper_pos == pre_shut_reg) ##1 $stable(wiper_pos) [*4];
  endsequence
  a_tap_decode: assert property (tap_select == (32'h0000_0001 << wiper_pos))
    else $error("tap select does not match wiper position");
  a_up_filtered: assert property (s_connected ##0 wiper_pos == $past(wiper_pos) + 5'h01
    |-> up_low_reg >= MIN_LOW) else $error("up step without a long enough press");
  a_down_filtered: assert property (s_connected ##0 wiper_pos == $past(wiper_pos) - 5'h01
    |-> dn_low_reg >= MIN_LOW) else $error("down step without a long enough press");
  a_no_wrap: assert property (s_connected |-> !($past(wiper_pos) == 5'h1f && wiper_pos == 5'h00)
    && !($past(wiper_pos) == 5'h00 && wiper_pos == 5'h1f)) else $error("position wrapped");
  a_idle_still: assert property (s_connected ##0 idle_reg > IDLE_LONG |-> $stable(wiper_pos))
    else $error("wiper moved with both step buttons released");
  a_shut_lowest: assert property (!chain_top_terminal |-> wiper_pos == 5'h00
    && tap_select == 32'h0000_0001) else $error("shutdown without lowest tap");
  a_shut_entry: assert property ($fell(chain_top_terminal) |-> up_low_reg >= SHUT_LOW
    && dn_low_reg >= SHUT_LOW) else $error("shutdown entered too early");
  a_shut_restore: assert property (live_reg == 2'h3 && $rose(chain_top_terminal)
    |-> s_restored) else $error("shutdown exit did not restore position alone");
  a_wr_pulse: assert property (nv_wr_start |=> !nv_wr_start)
    else $error("write start longer than one cycle");
  a_wr_data: assert property (nv_wr_start |-> nv_wr_data == wiper_pos)
    else $error("write data is not the current position");
  a_write_quiet: assert property (busy_reg && !nv_wr_start |-> $stable(wiper_pos))
    else $error("wiper moved during a store write");
endmodule

//--- verif/pbwc_far_model.sv
// far side: three push buttons with pull-ups and a nonvolatile store
// assumes the bench commands presses on press, just after a clock edge
`timescale 1ns/10ps
module pbwc_far_model #(
  parameter int WR_LAT = 20
) (
  input wire logic core_clk,
  input wire pbwc_pkg::pbwc_btn_s press,
  input wire logic preset_en,
  input wire logic [pbwc_pkg::POS_W-1:0] preset_val,
  input wire logic nv_wr_start,
  input wire logic [pbwc_pkg::POS_W-1:0] nv_wr_data,
  output logic step_up_button_n,
  output logic step_down_button_n,
  output logic store_mode_select_n,
  output logic [pbwc_pkg::POS_W-1:0] nv_rd_data,
  output logic nv_wr_done
);
  logic [pbwc_pkg::POS_W-1:0] mem_reg = 5'h10;
  logic [pbwc_pkg::POS_W-1:0] pend_reg = 5'h00;
  int lat_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // an open switch floats back high through the pull-up
  assign step_up_button_n = ~press.up;
  assign step_down_button_n = ~press.down;
  assign store_mode_select_n = ~press.store;
  // the stored word survives reset, so nothing here sees sys_rst
  assign nv_rd_data = mem_reg;
  // slow write: the word lands only when done pulses
  always_ff @(posedge core_clk)
  begin
    nv_wr_done <= (lat_cnt == 1);
    if (preset_en)
      mem_reg <= preset_val;
    else if (lat_cnt == 1)
      mem_reg <= pend_reg;
    if (nv_wr_start)
    begin
      pend_reg <= nv_wr_data;
      lat_cnt <= WR_LAT;
    end
    else if (lat_cnt > 0)
      lat_cnt <= lat_cnt - 1;
  end
endmodule

//--- verif/pbwc_wiper_ctrl_tb.sv
// self-checking bench for the push-button wiper control
// assumes the far model for buttons and store; the tick is shrunk to MS cycles
`timescale 1ns/10ps
module pbwc_wiper_ctrl_tb;
  localparam int MS = 10; // one scaled millisecond, keeps the run short
  localparam pbwc_pkg::pbwc_btn_s UP = 3'h4;
  localparam pbwc_pkg::pbwc_btn_s DN = 3'h2;
  localparam pbwc_pkg::pbwc_btn_s ST = 3'h1;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic step_up_button_n;
  logic step_down_button_n;
  logic store_mode_select_n;
  logic [pbwc_pkg::POS_W-1:0] nv_rd_data;
  logic nv_wr_done;
  logic nv_wr_start;
  logic [pbwc_pkg::POS_W-1:0] nv_wr_data;
  logic [pbwc_pkg::TAPS-1:0] tap_select;
  logic chain_top_terminal;
  logic [pbwc_pkg::POS_W-1:0] wiper_pos;
  pbwc_pkg::pbwc_btn_s press = 3'h0;
  logic preset_en = 1'b0;
  logic [pbwc_pkg::POS_W-1:0] preset_val = 5'h00;
  logic seen_wr = 1'b0;
  logic [pbwc_pkg::POS_W-1:0] seen_data = 5'h00;
  int err_total = 0;
  int n_tests = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  pbwc_wiper_ctrl #(.TICK_CYCLES(MS)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .step_up_button_n(step_up_button_n), .step_down_button_n(step_down_button_n),
    .store_mode_select_n(store_mode_select_n), .nv_rd_data(nv_rd_data),
    .nv_wr_done(nv_wr_done), .nv_wr_start(nv_wr_start), .nv_wr_data(nv_wr_data),
    .tap_select(tap_select), .chain_top_terminal(chain_top_terminal), .wiper_pos(wiper_pos));
  pbwc_far_model far_u (.core_clk(core_clk), .press(press), .preset_en(preset_en),
    .preset_val(preset_val), .nv_wr_start(nv_wr_start), .nv_wr_data(nv_wr_data),
    .step_up_button_n(step_up_button_n), .step_down_button_n(step_down_button_n),
    .store_mode_select_n(store_mode_select_n), .nv_rd_data(nv_rd_data),
    .nv_wr_done(nv_wr_done));
  // catch the one-cycle write pulse wherever it falls
  always @(posedge core_clk)
    if (nv_wr_start === 1'b1)
    begin
      seen_wr <= 1'b1;
      seen_data <= nv_wr_data;
    end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // press, release, then wait out the release filter plus the event gap
  task automatic hold(input pbwc_pkg::pbwc_btn_s b, input int ms);
    press = b;
    cyc(ms * MS);
    press = 3'h0;
    cyc(18 * MS);
  endtask
  task automatic chk_pos(input logic [4:0] v);
    chk("wiper_pos", {27'h0, v}, {27'h0, wiper_pos});
    chk("tap_select", 32'h0000_0001 << v, tap_select);
  endtask
  task automatic t_recall(input bit pre, input logic [4:0] v);
    preset_en = pre;
    preset_val = v;
    cyc(1);
    preset_en = 1'b0;
    sys_rst = 1'b1;
    cyc(16);
    sys_rst = 1'b0;
    cyc(4);
    chk_pos(v);
  endtask
  task automatic t_steps();
    hold(UP, 10);
    chk_pos(5'h07);
    hold(UP, 20);
    chk_pos(5'h08);
    hold(DN, 20);
    chk_pos(5'h07);
    hold(UP | DN, 40);
    chk_pos(5'h07);
  endtask
  task automatic t_save();
    int n;
    hold(UP, 20);
    seen_wr = 1'b0;
    press = ST;
    cyc(20 * MS);
    press = 3'h0;
    // the store fires on the filtered release, so allow a full filter time
    for (n = 0; n < 30 * MS && seen_wr !== 1'b1; n++)
      cyc(1);
    chk("nv_wr_start", 32'h0000_0001, {31'h0, seen_wr});
    chk("nv_wr_data", 32'h0000_0008, {27'h0, seen_data});
    cyc(1000);
    t_recall(1'b0, 5'h08);
  endtask
  task automatic t_ends();
    t_recall(1'b1, 5'h1f);
    hold(UP, 20);
    chk_pos(5'h1f);
    t_recall(1'b1, 5'h00);
    hold(DN, 20);
    chk_pos(5'h00);
  endtask
  // one step on press, four slow ones in the first second, then three fast
  task automatic t_repeat();
    hold(UP, 1200);
    chk_pos(5'h08);
  endtask
  task automatic t_shut();
    hold(UP | DN, 2100);
    chk("chain_top_terminal", 32'h0, {31'h0, chain_top_terminal});
    chk_pos(5'h00);
    hold(UP, 20);
    chk("chain_top_terminal", 32'h1, {31'h0, chain_top_terminal});
    chk_pos(5'h08);
  endtask
  // store pin held low through reset selects the idle save
  task automatic t_auto();
    int n;
    press = ST;
    t_recall(1'b1, 5'h03);
    hold(UP | ST, 20);
    seen_wr = 1'b0;
    cyc(1900 * MS);
    chk("early nv_wr_start", 32'h0, {31'h0, seen_wr});
    for (n = 0; n < 200 * MS && seen_wr !== 1'b1; n++)
      cyc(1);
    chk("nv_wr_data", 32'h0000_0004, {27'h0, seen_data});
    cyc(100);
    t_recall(1'b0, 5'h04);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_recall(1'b1, 5'h07);
    t_steps();
    t_save();
    t_ends();
    t_repeat();
    t_shut();
    t_auto();
    end_sim();
  end
endmodule
bind pbwc_wiper_ctrl pbwc_wiper_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst),
  .step_up_button_n(step_up_button_n), .step_down_button_n(step_down_button_n),
  .store_mode_select_n(store_mode_select_n), .nv_rd_data(nv_rd_data),
  .nv_wr_done(nv_wr_done), .nv_wr_start(nv_wr_start), .nv_wr_data(nv_wr_data),
  .tap_select(tap_select), .chain_top_terminal(chain_top_terminal), .wiper_pos(wiper_pos));
